// File: rtl/afd_top.sv
// four-channel amplifier output fault diagnostic with avalon-mm register slave
//
// Local design decisions: the address map and the Avalon-MM interface to the registers.
`default_nettype none

module afd_top
	import afd_pkg::*;
#(
	parameter int N_CH        = 4,
	parameter int RESTART_CNT = RESTART_CYC,
	parameter int PLATEAU_CNT = PLATEAU_CYC
)
(
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst,
	// avalon-mm slave
	input  wire logic [7:0]            i_avs_address,
	input  wire logic                  i_avs_read,
	input  wire logic                  i_avs_write,
	input  wire logic [31:0]           i_avs_writedata,
	input  wire logic [3:0]            i_avs_byteenable,
	output logic      [31:0]           o_avs_readdata,
	output logic                       o_avs_waitrequest,
	// per-channel sense from the output stage
	input  wire afd_ch_sense_t [N_CH-1:0] i_ch_sense,
	output logic      [N_CH-1:0]       o_ch_shutdown,
	output logic      [N_CH-1:0]       o_ch_plateau,
	// ac diagnostic sense, threshold select out
	input  wire afd_ac_sense_t [N_CH-1:0] i_ac_sense,
	output logic                       o_ac_active,
	output logic                       o_ac_thr_sel,
	input  wire logic                  i_ac_sig_high,
	// audio sample path
	input  wire logic                  i_smp_valid,
	input  wire logic signed [23:0]    i_smp_data,
	output logic                       o_smp_valid,
	output logic signed [23:0]         o_smp_data,
	input  wire logic                  i_play,
	// thermal
	input  wire logic [3:0]            i_thermal_warn,
	output logic                       o_clip_diag_out_pin
);

	// ==========================================================
	// configuration registers
	// ==========================================================
	logic [7:0]        diag_config_byte;          // permanent, ac enable, ac threshold
	logic [7:0]        audio_filter_config_byte;  // high-pass select
	logic [1:0]        thw_sel;                   // thermal warning pin routing
	logic [7:0]        ch_result [N_CH];          // per-channel result bytes
	logic [7:0]        ac_diag_result_byte;       // tweeter presence and validity
	logic              offs_flag;                 // sticky input offset flag
	logic [3:0]        thermal_flags;             // thermal warning levels
	logic              rd_ack;                    // one-cycle wait before read answer
	logic [31:0]       next_rdata;                // decoded read data
	logic              wr_hit;                    // write accepted this edge
	logic              rd_hit;                    // read accepted this edge
	logic              rd_ch4;                    // read of last channel byte
	logic              rd_any_ch;                 // read of any channel byte
	logic [N_CH-1:0]   ch_res_read;               // per-channel byte read this edge

	wire perm_en = diag_config_byte[DCFG_PERM_BIT];

	// ==========================================================
	// bus slave: writes answer at once, reads take one wait cycle
	// ==========================================================
	assign o_avs_waitrequest = i_avs_read & ~rd_ack;
	assign wr_hit = i_avs_write;
	assign rd_hit = i_avs_read & rd_ack;
	assign rd_ch4 = rd_hit && (i_avs_address == ADDR_CH4_RES);     // R12
	assign rd_any_ch = rd_hit && (i_avs_address >= ADDR_CH1_RES)
		&& (i_avs_address <= ADDR_CH4_RES);

	// read acknowledge toggles so each read is answered once
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			rd_ack <= 1'b0;
		else
			rd_ack <= i_avs_read & ~rd_ack;
	end

	// read data mux; unmapped addresses read zero
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (i_avs_address)
			ADDR_DIAG_CFG: next_rdata[7:0] = diag_config_byte;
			ADDR_FILT_CFG: next_rdata[7:0] = audio_filter_config_byte;
			ADDR_THW_SEL:  next_rdata[1:0] = thw_sel;
			ADDR_AC_RES:   next_rdata[7:0] = ac_diag_result_byte;
			ADDR_STATUS:   next_rdata[4:0] = {offs_flag, thermal_flags};   // R22
			default:
			begin
				for (int k = 0; k < N_CH; k++)
					if (i_avs_address == ADDR_CH1_RES + 8'(4 * k))
						next_rdata[7:0] = ch_result[k];
			end
		endcase
	end

	// read data register, loaded during the wait cycle
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_avs_read & ~rd_ack)
			o_avs_readdata <= next_rdata;
	end

	// configuration writes honour byte lane zero only
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			diag_config_byte         <= DCFG_RST;
			audio_filter_config_byte <= FCFG_RST;
			thw_sel                  <= THW_RST;
		end
		else if (wr_hit && i_avs_byteenable[0])
		begin
			if (i_avs_address == ADDR_DIAG_CFG)
				diag_config_byte <= i_avs_writedata[7:0];
			if (i_avs_address == ADDR_FILT_CFG)
				audio_filter_config_byte <= i_avs_writedata[7:0];
			if (i_avs_address == ADDR_THW_SEL)
				thw_sel <= i_avs_writedata[1:0];
		end
	end

	// ==========================================================
	// per-channel restart / plateau sequencer
	// ==========================================================
	genvar g;
	generate
		for (g = 0; g < N_CH; g++)
		begin : g_ch                                                   // R23
			afd_state_t  state;       // sequencer state
			logic [23:0] tmr;         // cycle timer
			logic        recall;      // plateau requested by host read
			logic [2:0]  fault_code;  // prioritised fault, gnd/vs/load

			assign ch_res_read[g] = rd_hit
				&& (i_avs_address == ADDR_CH1_RES + 8'(4 * g));

			// shorts to ground or supply win over short across load
			always_comb
			begin
				fault_code = 3'b000;
				if (i_ch_sense[g].short_gnd)
					fault_code[RES_SGND_BIT] = 1'b1;                   // R20
				else if (i_ch_sense[g].short_vs)
					fault_code[RES_SVS_BIT] = 1'b1;                    // R20
				else if (i_ch_sense[g].short_load)
					fault_code[RES_SLOAD_BIT] = 1'b1;
			end

			// state and timer: restart pulse, then plateau or replay
			always_ff @(posedge i_sys_clk)
			begin
				if (i_rst)
				begin
					state  <= AFD_ST_PLAY;
					tmr    <= 24'h00_0000;
					recall <= 1'b0;
				end
				else
				begin
					// a read recalls a plateau only while the fault persists
					if (state == AFD_ST_RESTART && perm_en && rd_any_ch
						&& i_ch_sense[g].over_current)
						recall <= 1'b1;                                // R9 R10
					unique case (state)
						AFD_ST_PLAY:
						begin
							tmr <= 24'h00_0000;
							if (i_ch_sense[g].over_current)
								state <= AFD_ST_RESTART;               // R3 R5
						end
						AFD_ST_RESTART:
						begin
							if (tmr == 24'(RESTART_CNT - 1))           // R1
							begin
								tmr <= 24'h00_0000;
								if (!i_ch_sense[g].over_current)
								begin
									state  <= AFD_ST_PLAY;             // R6
									recall <= 1'b0;
								end
								else if (perm_en && (recall || !ch_result[g][RES_PLAT_BIT]))
								begin
									state  <= AFD_ST_PLATEAU;          // R7 R9
									recall <= 1'b0;
								end
								// else keep restarting every pulse  R3 R8
							end
							else
								tmr <= tmr + 24'h00_0001;
						end
						AFD_ST_PLATEAU:
						begin
							if (tmr == 24'(PLATEAU_CNT - 1))           // R2
							begin
								tmr   <= 24'h00_0000;
								state <= AFD_ST_RESTART;               // R8
							end
							else
								tmr <= tmr + 24'h00_0001;
						end
						default:
							state <= AFD_ST_PLAY;
					endcase
				end
			end

			assign o_ch_shutdown[g] = (state != AFD_ST_PLAY);          // R3 R5
			assign o_ch_plateau[g]  = (state == AFD_ST_PLATEAU);

			// result byte: plateau writes findings, last-byte read clears all
			always_ff @(posedge i_sys_clk)
			begin
				if (i_rst)
					ch_result[g] <= 8'h00;
				else if (!perm_en)
					ch_result[g] <= 8'h00;                             // R4
				else if (state == AFD_ST_PLATEAU && tmr == 24'(PLATEAU_CNT - 1))
					ch_result[g] <= {2'b00, 1'b1, 2'b00, fault_code};  // R11 R21
				else if (rd_ch4)
					ch_result[g] <= 8'h00;                             // R12
				else if (state == AFD_ST_PLATEAU)
					ch_result[g][2:0] <= ch_result[g][2:0] | fault_code;   // R2
			end

			// ac test: count periods with no threshold crossing
			logic [2:0] miss_cnt;
			always_ff @(posedge i_sys_clk)
			begin
				if (i_rst)
					miss_cnt <= 3'h0;
				else if (!diag_config_byte[DCFG_AC_EN_BIT])
					miss_cnt <= 3'h0;
				else if (i_ac_sense[g].period_end)
				begin
					if (i_ac_sense[g].crossed)
						miss_cnt <= 3'h0;
					else if (miss_cnt != 3'(AC_MISS_PERIODS))
						miss_cnt <= miss_cnt + 3'h1;                   // R14
				end
			end

			// present bit: one unless four misses in a row
			always_ff @(posedge i_sys_clk)
			begin
				if (i_rst)
					ac_diag_result_byte[AC_RES_LSB + g] <= 1'b0;
				else if (diag_config_byte[DCFG_AC_EN_BIT] && i_ac_sense[g].period_end)
					ac_diag_result_byte[AC_RES_LSB + g] <=
						i_ac_sense[g].crossed || (miss_cnt < 3'(AC_MISS_PERIODS - 1)); // R15
			end
		end
	endgenerate

	// ==========================================================
	// ac diagnostic validity and unused bits
	// ==========================================================
	assign o_ac_active  = diag_config_byte[DCFG_AC_EN_BIT];           // R13
	assign o_ac_thr_sel = diag_config_byte[DCFG_AC_THR_BIT];          // R13

	// validity bit: drops low while the test signal is too high
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			ac_diag_result_byte[AC_VALID_BIT] <= AC_RST[AC_VALID_BIT];
		else if (diag_config_byte[DCFG_AC_EN_BIT])
			ac_diag_result_byte[AC_VALID_BIT] <= ~i_ac_sig_high;       // R16
	end
	assign ac_diag_result_byte[2:0] = 3'b000;

	// ==========================================================
	// input offset detector and high-pass filter
	// ==========================================================
	logic signed [35:0] dc_acc;    // leaky integrator of the input level
	wire  signed [23:0] dc_est = dc_acc[35:12];
	wire  [23:0]        dc_mag = dc_est[23] ? 24'(-dc_est) : dc_est;

	// the tracker runs only in play, keeping mute silence out of the estimate
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			dc_acc <= 36'sh0_0000_0000;
		else if (i_smp_valid && i_play)                                // R19
			dc_acc <= dc_acc + 36'(i_smp_data) - 36'(dc_est);
	end

	// offset flag is sticky until the status byte is read; a new detection wins
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			offs_flag <= 1'b0;
		else if (i_play && dc_mag > OFFS_THR)
			offs_flag <= 1'b1;                                         // R17
		else if (rd_hit && i_avs_address == ADDR_STATUS)
			offs_flag <= 1'b0;
	end

	// output sample register: subtract estimated dc when filter selected
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			o_smp_valid <= 1'b0;
			o_smp_data  <= 24'sh00_0000;
		end
		else
		begin
			o_smp_valid <= i_smp_valid;
			if (i_smp_valid)
				o_smp_data <= audio_filter_config_byte[FCFG_HPF_BIT]
					? 24'(i_smp_data - dc_est) : i_smp_data;           // R18
		end
	end

	// ==========================================================
	// thermal warnings
	// ==========================================================
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			thermal_flags <= 4'h0;
		else
			thermal_flags <= i_thermal_warn;                           // R22
	end

	// one selected warning drives the clip/diag pin
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			o_clip_diag_out_pin <= 1'b0;
		else
			o_clip_diag_out_pin <= thermal_flags[thw_sel];             // R22
	end

endmodule : afd_top

`default_nettype wire

// File: include/afd_pkg.sv
// package of constants and carrier types for the amplifier output fault diagnostic
//
// Overview of operation
// R1: restart cycle is a 2 ms checked pulse
// R2: plateau cycle lasts 80 ms, writes results
// R3: restart mode: shut channel, retry every 2 ms
// R4: restart mode clears and disables fault reporting
// R5: diagnostic mode self-activates on channel overload
// R6: first one restart; clear fault resumes play
// R7: fault persists after restart: run plateau
// R8: after plateau, restart every 2 ms, hold results
// R9: result byte read during restart recalls plateau
// R10: no plateau recall when overload already gone
// R11: plateau completion sets bit five of result
// R12: reading channel four byte clears all four
// R13: ac diagnostic enable bit three, threshold bit four
// R14: tweeter absent after four uncrossed sine periods
// R15: ac results in bits three to six
// R16: bit seven low when test signal too high
// R17: flag input offset above minus 19.5 dBFS
// R18: high-pass select removes input dc offset
// R19: offset detect and filter usable in play
// R20: shorts to supply rails beat load faults
// R21: permanent diagnostic never reports open or soft
// R22: four thermal flags, one routed to pin
// R23: independent sequencer per channel, core clock timed
`default_nettype none

package afd_pkg;

	// ==========================================================
	// timing
	// ==========================================================
	localparam int CLK_HZ           = 125_000_000;   // core clock rate
	localparam int RESTART_TIME_US  = 2_000;         // restart pulse length
	localparam int PLATEAU_TIME_US  = 80_000;        // plateau cycle length
	localparam int RESTART_CYC      = (CLK_HZ / 1_000_000) * RESTART_TIME_US;
	localparam int PLATEAU_CYC      = (CLK_HZ / 1_000_000) * PLATEAU_TIME_US;
	localparam int AC_MISS_PERIODS  = 4;             // sine periods without crossing

	// ==========================================================
	// register offsets (byte addresses, one word each)
	// ==========================================================
	localparam logic [7:0] ADDR_DIAG_CFG   = 8'h00; // diag_config_byte
	localparam logic [7:0] ADDR_FILT_CFG   = 8'h04; // audio_filter_config_byte
	localparam logic [7:0] ADDR_THW_SEL    = 8'h08; // thermal warning pin select
	localparam logic [7:0] ADDR_CH1_RES    = 8'h10; // ch1_result_byte
	localparam logic [7:0] ADDR_CH4_RES    = 8'h1C; // ch4_result_byte
	localparam logic [7:0] ADDR_AC_RES     = 8'h20; // ac_diag_result_byte
	localparam logic [7:0] ADDR_STATUS     = 8'h24; // thermal and offset flags

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int DCFG_PERM_BIT    = 0;   // permanent diagnostic select
	localparam int DCFG_AC_EN_BIT   = 3;   // ac diagnostic enable
	localparam int DCFG_AC_THR_BIT  = 4;   // ac threshold select
	localparam int FCFG_HPF_BIT     = 0;   // high-pass filter select
	localparam int RES_SGND_BIT     = 0;   // short to ground
	localparam int RES_SVS_BIT      = 1;   // short to supply
	localparam int RES_SLOAD_BIT    = 2;   // short across load
	localparam int RES_PLAT_BIT     = 5;   // plateau done
	localparam int AC_RES_LSB       = 3;   // first tweeter present bit
	localparam int AC_VALID_BIT     = 7;   // low: test signal too high
	localparam int STAT_OFFS_BIT    = 4;   // input offset flag

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [7:0] DCFG_RST = 8'h00;
	localparam logic [7:0] FCFG_RST = 8'h00;
	localparam logic [1:0] THW_RST  = 2'h0;
	localparam logic [7:0] AC_RST   = 8'h80;

	// offset threshold: -19.5 dBFS of full scale 2^23 is 0.10593 * 2^23
	localparam logic [23:0] OFFS_THR  = 24'h0D_8EF7;
	localparam int          HPF_SHIFT = 12;          // dc tracker time constant

	// ==========================================================
	// carriers
	// ==========================================================
	typedef enum logic [1:0]
	{
		AFD_ST_PLAY    = 2'b00,
		AFD_ST_RESTART = 2'b01,
		AFD_ST_PLATEAU = 2'b10
	} afd_state_t;

	typedef struct packed
	{
		logic over_current;  // overload seen by the output stage
		logic short_gnd;     // short to ground detected
		logic short_vs;      // short to supply detected
		logic short_load;    // short across load detected
	} afd_ch_sense_t;

	typedef struct packed
	{
		logic period_end;    // end of one test sine period
		logic crossed;       // current crossed threshold this period
	} afd_ac_sense_t;

endpackage : afd_pkg

`default_nettype wire

// File: verif/afd_top_monitor.sv
// checker on the fault diagnostic top ports
`default_nettype none

module afd_top_monitor
	import afd_pkg::*;
#(
	parameter int N_CH        = 4,
	parameter int RESTART_CNT = 20,
	parameter int PLATEAU_CNT = 80
)
(
	input wire logic                      i_sys_clk,
	input wire logic                      i_rst,
	input wire logic [7:0]                i_avs_address,
	input wire logic                      i_avs_read,
	input wire logic                      i_avs_write,
	input wire logic [31:0]               i_avs_writedata,
	input wire logic [3:0]                i_avs_byteenable,
	input wire logic                      o_avs_waitrequest,
	input wire afd_ch_sense_t [N_CH-1:0]  i_ch_sense,
	input wire logic [N_CH-1:0]           o_ch_shutdown,
	input wire logic [N_CH-1:0]           o_ch_plateau,
	input wire logic                      o_ac_active,
	input wire logic                      o_ac_thr_sel,
	input wire logic                      i_smp_valid,
	input wire logic                      o_smp_valid
);
	// ==========================================================
	// helper state
	// ==========================================================
	logic [N_CH-1:0] oc;   // over-current per channel
	logic [15:0]     run;  // channel 0 restart cycles in a row
	logic [15:0]     pc;   // channel 0 plateau cycles in a row
	logic            perm; // permanent diagnostic select, from bus writes
	logic            cfgw; // write to the diagnostic config

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	assign cfgw = i_avs_write && i_avs_address == ADDR_DIAG_CFG && i_avs_byteenable[0];

	// unpack the over-current flags
	always_comb
	begin
		for (int k = 0; k < N_CH; k++)
			oc[k] = i_ch_sense[k].over_current;
	end

	// run lengths of channel 0, so spans can be checked as multiples
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			run <= '0;
		else if (o_ch_shutdown[0] && !o_ch_plateau[0])
			run <= run + 1'b1;
		else
			run <= '0;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			pc <= '0;
		else if (o_ch_plateau[0])
			pc <= pc + 1'b1;
		else
			pc <= '0;
	end

	// shadow of the select bit; a clear racing a restart end is not covered
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			perm <= 1'b0;
		else if (cfgw)
			perm <= i_avs_writedata[DCFG_PERM_BIT];
	end

	// ==========================================================
	// assertions
	// ==========================================================
	a_wait_one: assert property ($rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("read wait is not one cycle");
	a_only_fault: assert property ((o_ch_shutdown & ~$past(o_ch_shutdown) & ~$past(oc)) == '0)
		else $error("channel shut without overload");
	a_shut_oc: assert property ((~o_ch_shutdown & $past(oc) & ~$past(o_ch_shutdown)) == '0)
		else $error("overload did not shut channel");
	a_restart_span: assert property ($rose(o_ch_plateau[0]) |-> run != 0 && run % RESTART_CNT == 0)
		else $error("plateau not at restart end");
	a_resume_span: assert property ($fell(o_ch_shutdown[0]) |-> run != 0 && run % RESTART_CNT == 0)
		else $error("play resumed off a restart end");
	a_plat_span: assert property ($fell(o_ch_plateau[0]) |-> pc == PLATEAU_CNT)
		else $error("plateau length wrong");
	a_plat_back: assert property ($fell(o_ch_plateau[0]) |-> o_ch_shutdown[0])
		else $error("no restart after plateau");
	a_no_plat_off: assert property (!perm |-> (o_ch_plateau & ~$past(o_ch_plateau)) == '0)
		else $error("plateau in restart mode");
	a_ac_cfg: assert property (cfgw |=> {o_ac_thr_sel, o_ac_active} == $past(i_avs_writedata[4:3]))
		else $error("ac config outputs wrong");
	a_smp_valid: assert property (i_smp_valid |=> o_smp_valid)
		else $error("sample not passed on");
endmodule // afd_top_monitor

bind afd_top afd_top_monitor #(.N_CH(N_CH), .RESTART_CNT(RESTART_CNT), .PLATEAU_CNT(PLATEAU_CNT))
	u_mon (.i_sys_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
	.i_avs_byteenable, .o_avs_waitrequest, .i_ch_sense, .o_ch_shutdown, .o_ch_plateau,
	.o_ac_active, .o_ac_thr_sel, .i_smp_valid, .o_smp_valid);

`default_nettype wire

// File: verif/afd_host.sv
// host model speaking avalon-mm to the register slave
`default_nettype none

module afd_host
(
	input  wire logic        i_sys_clk,
	input  wire logic [31:0] i_readdata,
	input  wire logic        i_waitrequest,
	output logic      [7:0]  o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [31:0] o_writedata,
	output logic      [3:0]  o_byteenable
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial
	begin
		o_address    = 8'h00;
		o_read       = 1'b0;
		o_write      = 1'b0;
		o_writedata  = 32'h0000_0000;
		o_byteenable = 4'h0;
	end

	// hold the request until waitrequest is sampled low at a rising edge, then release
	task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
		input logic w, output logic [31:0] q);
		@(posedge i_sys_clk);
		o_address    <= a;
		o_writedata  <= d;
		o_byteenable <= be;
		o_write      <= w;
		o_read       <= !w;
		@(posedge i_sys_clk);
		while (i_waitrequest)
			@(posedge i_sys_clk);
		q = i_readdata;
		o_write      <= 1'b0;
		o_read       <= 1'b0;
		// released address and data lines show the inverse so stale values never look valid
		o_address    <= ~a;
		o_writedata  <= ~d;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
		logic [31:0] q;
		xfer(a, {24'h00_0000, d}, be, 1'b1, q);
	endtask

	// reading a channel byte during a restart with the overload still present recalls a plateau; channel four read clears all
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(a, 32'h0000_0000, 4'hf, 1'b0, q);
	endtask
endmodule // afd_host

`default_nettype wire

// File: verif/afd_top_tb.sv
// self-checking bench for the amplifier output fault diagnostic
`default_nettype none

module afd_top_tb
	import afd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// signals
	// ==========================================================
	localparam int RC = 20;              // shortened restart count
	localparam int PC = 80;              // shortened plateau count
	logic                i_sys_clk, i_rst;
	logic [7:0]          adr;
	logic                rd_s, wr_s, wreq, sig_high, sv, ov, play, pin, ac_act, ac_thr;
	logic [31:0]         wdat, rdat, q, r, e;
	logic [3:0]          be, shut, plat, thw;
	afd_ch_sense_t [3:0] sense;
	afd_ac_sense_t [3:0] acs;
	logic signed [23:0]  sd, od;
	logic signed [23:0]  sq[$];          // samples awaiting output
	int                  miss[4];        // consecutive uncrossed periods
	int                  bad_count, samples_checked, k;

	afd_top #(.RESTART_CNT(RC), .PLATEAU_CNT(PC)) dut (.i_sys_clk, .i_rst,
		.i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdat),
		.i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.i_ch_sense(sense), .o_ch_shutdown(shut), .o_ch_plateau(plat), .i_ac_sense(acs),
		.o_ac_active(ac_act), .o_ac_thr_sel(ac_thr), .i_ac_sig_high(sig_high),
		.i_smp_valid(sv), .i_smp_data(sd), .o_smp_valid(ov), .o_smp_data(od), .i_play(play),
		.i_thermal_warn(thw), .o_clip_diag_out_pin(pin));
	afd_host host (.i_sys_clk, .i_readdata(rdat), .i_waitrequest(wreq), .o_address(adr),
		.o_read(rd_s), .o_write(wr_s), .o_writedata(wdat), .o_byteenable(be));

	// ==========================================================
	// helpers
	// ==========================================================
	initial
	begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end

	function automatic logic [31:0] xs();
		r = r ^ (r << 13);
		r = r ^ (r >> 17);
		r = r ^ (r << 5);
		return r;
	endfunction

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x)
		begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string n);
		host.rd(a, q);
		chk(n, x, q);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask

	// bounded wait for the channel 0 plateau flag
	task automatic wplat(input logic v, input int lim, input string n);
		int c;
		c = 0;
		while (plat[0] !== v && c < lim)
		begin
			@(negedge i_sys_clk);
			c++;
		end
		chk(n, {31'h0, v}, {31'h0, plat[0]});
	endtask

	task automatic setoc(input int ch, input logic [3:0] v);
		@(posedge i_sys_clk);
		sense[ch] <= v;
	endtask

	// one test-tone period end; the model counts misses per channel
	task automatic ac_period(input logic [3:0] c);
		@(posedge i_sys_clk);
		for (k = 0; k < 4; k++)
		begin
			acs[k].period_end <= 1'b1;
			acs[k].crossed    <= c[k];
			miss[k] = c[k] ? 0 : miss[k] + 1;
		end
		@(posedge i_sys_clk);
		for (k = 0; k < 4; k++)
			acs[k].period_end <= 1'b0;
		cyc(2);
	endtask

	function automatic logic [31:0] ac_exp();
		logic [31:0] x;
		x = {24'h0, !sig_high, 7'h0};
		for (int i = 0; i < 4; i++)
			x[AC_RES_LSB + i] = miss[i] < AC_MISS_PERIODS;
		return x;
	endfunction

	// one sample; with the filter off it must come out unchanged
	task automatic samp(input logic signed [23:0] d, input logic cmp);
		@(posedge i_sys_clk);
		sv <= 1'b1;
		sd <= d;
		sq.push_back(d);
		@(posedge i_sys_clk);
		sv <= 1'b0;
		sd <= ~d;
		@(negedge i_sys_clk);
		e = {8'h0, sq.pop_front()};
		if (cmp)
		begin
			chk("smp_valid", 32'h1, {31'h0, ov});
			chk("smp_data", e, {8'h0, od});
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog sized well above the roughly 12.5k cycles of the sequence
	initial
	begin
		repeat (60000) @(posedge i_sys_clk);
		bad_count++;
		stop_test();
	end

	// ==========================================================
	// main sequence
	// ==========================================================
	initial
	begin
		i_rst = 1'b1;
		r = 32'h5d4a_ae4c;
		sense = '0;
		acs = '0;
		sig_high = 1'b0;
		sv = 1'b0;
		sd = '0;
		play = 1'b1;
		thw = 4'h0;
		bad_count = 0;
		samples_checked = 0;
		miss = '{0, 0, 0, 0};
		cyc(6);
		i_rst <= 1'b0;
		rchk(ADDR_DIAG_CFG, 32'h0, "diag_rst");
		rchk(ADDR_AC_RES, {24'h0, AC_RST}, "ac_rst");
		host.wr(ADDR_DIAG_CFG, 8'h01, 4'h0);
		rchk(ADDR_DIAG_CFG, 32'h0, "be_off");
		host.wr(8'h30, 8'hff, 4'hf);
		rchk(8'h30, 32'h0, "unmapped");
		// restart mode: only channel 4 stops, nothing is reported
		setoc(3, 4'b1100);
		cyc(3 * RC);
		chk("shut_one", 32'h8, {28'h0, shut});
		rchk(ADDR_CH4_RES, 32'h0, "ch4_quiet");
		setoc(3, 4'b0000);
		cyc(RC + 4);
		chk("shut_off", 32'h0, {28'h0, shut});
		// diagnostic mode on channel 1 with random shorts plus a load short
		host.wr(ADDR_DIAG_CFG, 8'h01, 4'hf);
		void'(xs());
		e = {26'h0, 1'b1, 2'b00, !r[0] && !r[1], r[1] && !r[0], r[0]};
		setoc(0, {1'b1, r[0], r[1] && !r[0], 1'b1});
		wplat(1'b1, RC + 4, "plat_rise");
		wplat(1'b0, PC + 4, "plat_end");
		cyc(2 * RC);
		chk("no_replat", 32'h0, {31'h0, plat[0]});
		rchk(ADDR_CH1_RES, e, "ch1_res");
		wplat(1'b1, RC + 4, "recall");
		wplat(1'b0, PC + 4, "recall_end");
		setoc(0, 4'b0000);
		rchk(ADDR_CH1_RES, e, "ch1_held");
		cyc(RC + 4);
		chk("no_recall", 32'h0, {30'h0, plat[0], shut[0]});
		rchk(ADDR_CH4_RES, 32'h0, "ch4_res");
		rchk(ADDR_CH1_RES, 32'h0, "ch1_clr");
		// ac diagnostic: channels 2 and 4 miss four periods
		host.wr(ADDR_DIAG_CFG, 8'h18, 4'hf);
		cyc(1);
		chk("ac_cfg", 32'h3, {30'h0, ac_thr, ac_act});
		for (int p = 0; p < 4; p++)
			ac_period({1'b0, p == 3, 1'b0, 1'b1});
		rchk(ADDR_AC_RES, ac_exp(), "ac_res");
		@(posedge i_sys_clk);
		sig_high <= 1'b1;
		ac_period(4'hf);
		rchk(ADDR_AC_RES, ac_exp(), "ac_high");
		// offset flag and pass-through, then the filter removes dc
		@(posedge i_sys_clk);
		thw <= 4'(xs());
		samp(24'sh20_0000, 1'b1);
		rchk(ADDR_STATUS, {28'h0, thw}, "no_offs");
		host.wr(ADDR_FILT_CFG, 8'h01, 4'hf);
		repeat (6000) samp(24'sh20_0000, 1'b0);
		chk("hpf", 32'h1, {31'h0, od < 24'sh08_0000 && od > -24'sh08_0000});
		rchk(ADDR_STATUS, {27'h0, 1'b1, thw}, "status");
		// each thermal flag in turn reaches the pin
		for (int s = 0; s < 4; s++)
		begin
			host.wr(ADDR_THW_SEL, s[7:0], 4'hf);
			@(posedge i_sys_clk);
			thw <= 4'(xs());
			cyc(3);
			chk("pin", {31'h0, r[s]}, {31'h0, pin});
		end
		stop_test();
	end
endmodule // afd_top_tb

`default_nettype wire
